// ---- hdl/instr_decode.sv ----
`include "instr_decode_regs.svh"
module instr_decode
   import instr_decode_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Execution results
   output logic [15:0] pc_o,
   output logic [7:0] flags_o,
   output logic [7:0] irq_ctrl_o,
   output logic halt_o,
   output logic pass_o,
   output logic [7:0] pass_opcode_o
);
   import instr_decode_pkg::*;
   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   logic wr_pend_r, wr_pend_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic [31:0] rdata_nxt;
   logic go_pulse;
   logic [7:0] opcode_r, opcode_nxt;
   logic [15:0] operand_r, operand_nxt;
   logic [7:0] wreg_r, wreg_nxt;
   logic [7:0] stack_flags_r, stack_flags_nxt;
   logic [15:0] stack_pc_r, stack_pc_nxt;
   logic [15:0] sp_r, sp_nxt;
   logic [7:0] flags_r, flags_nxt;
   logic [15:0] pc_r, pc_nxt;
   logic [7:0] icr_r, icr_nxt;
   logic halt_r, halt_nxt;
   logic pass_r, pass_nxt;
   logic [7:0] pass_op_r, pass_op_nxt;
   seq_state_t st_r, st_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic lookup_r, lookup_nxt;
   logic [2:0] fcyc;
   logic [2:0] ecyc;
   logic [3:0] mode;
   logic [17:0] fx;
   logic hit;
   logic addr_ph;
   assign addr_ph = hsel_i && hready_i && htrans_i[1];
   always_comb begin
      wr_pend_nxt = addr_ph && hwrite_i;
      addr_nxt = addr_ph ? haddr_i : addr_r;
      go_pulse = 1'b0;
      opcode_nxt = opcode_r;
      operand_nxt = operand_r;
      wreg_nxt = wreg_r;
      stack_flags_nxt = stack_flags_r;
      stack_pc_nxt = stack_pc_r;
      if (wr_pend_r) begin
         case (addr_r)
            `DEC_OFS_CTRL: go_pulse = hwdata_i[`DEC_CTRL_GO_BIT];
            `DEC_OFS_OPCODE: begin
               opcode_nxt = hwdata_i[7:0];
               operand_nxt = hwdata_i[23:8];
               wreg_nxt = hwdata_i[31:24];
            end
            `DEC_OFS_INFO: begin
               stack_flags_nxt = hwdata_i[7:0];
               stack_pc_nxt = hwdata_i[23:8];
            end
            default: ;
         endcase
      end
      rdata_nxt = 32'h0000_0000;
      if (addr_ph && !hwrite_i) begin
         case (haddr_i)
            `DEC_OFS_OPCODE: rdata_nxt = {wreg_r, operand_r, opcode_r};
            `DEC_OFS_STATUS: rdata_nxt = {24'h00_0000, 4'h0, pass_r, icr_r[7],
               halt_r, (st_r != ST_IDLE)};
            `DEC_OFS_FLAGS: rdata_nxt = {8'h00, sp_r[7:0], flags_r, pass_op_r};
            `DEC_OFS_INFO: rdata_nxt = {8'h00, pc_r, {1'b0, cnt_r, mode}};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // Sequencer and execution
   // ---------------------------------------------------------------
   logic cond_true;
   logic [7:0] wdec;
   always_comb begin
      case (opcode_r[7:4])
         4'h8: cond_true = 1'b1;
         4'h0: cond_true = 1'b0;
         4'h6: cond_true = flags_r[6];
         4'hE: cond_true = !flags_r[6];
         4'h7: cond_true = flags_r[7];
         4'hF: cond_true = !flags_r[7];
         4'hD: cond_true = flags_r[5];
         4'h5: cond_true = !flags_r[5];
         default: cond_true = flags_r[4];
      endcase
   end
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      lookup_nxt = 1'b0;
      flags_nxt = flags_r;
      pc_nxt = pc_r;
      icr_nxt = icr_r;
      halt_nxt = halt_r;
      pass_nxt = 1'b0;
      pass_op_nxt = pass_op_r;
      sp_nxt = sp_r;
      wdec = wreg_r - 8'h01;
      case (st_r)
         ST_IDLE: begin
            if (go_pulse) lookup_nxt = 1'b1;
            if (lookup_r) begin
               if (!hit) begin
                  pass_nxt = 1'b1;
                  pass_op_nxt = opcode_r;
               end else begin
                  st_nxt = ST_FETCH;
                  cnt_nxt = fcyc - 3'h1;
               end
            end
         end
         ST_FETCH: begin
            if (cnt_r == 3'h0) begin
               st_nxt = ST_EXEC;
               cnt_nxt = ecyc - 3'h1;
            end else cnt_nxt = cnt_r - 3'h1;
         end
         ST_EXEC: begin
            if (cnt_r == 3'h0) begin
               st_nxt = ST_IDLE;
               if (opcode_r == 8'h8F) icr_nxt[`DEC_IRQ_ENABLE_BIT] = 1'b0;
               if (opcode_r == 8'h9F) icr_nxt[`DEC_IRQ_ENABLE_BIT] = 1'b1;
               if (opcode_r == 8'h7F) halt_nxt = 1'b1;
               if (opcode_r == 8'hBF) begin
                  flags_nxt = stack_flags_r;
                  pc_nxt = stack_pc_r;
                  sp_nxt = sp_r + 16'h0003;
                  icr_nxt[`DEC_IRQ_ENABLE_BIT] = 1'b1;
               end
               if (opcode_r == 8'h8D || opcode_r == 8'hC4) pc_nxt = operand_r;
               if (opcode_r[3:0] == 4'hD && cond_true) pc_nxt = operand_r;
               if (opcode_r[3:0] == 4'hA && wdec != 8'h00)
                  pc_nxt = pc_r + {{8{operand_r[7]}}, operand_r[7:0]};
            end else cnt_nxt = cnt_r - 3'h1;
         end
         default: st_nxt = ST_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_pend_r <= 1'b0;
         addr_r <= 8'h00;
         hrdata_o <= 32'h0000_0000;
         opcode_r <= 8'h00;
         operand_r <= 16'h0000;
         wreg_r <= 8'h00;
         stack_flags_r <= 8'h00;
         stack_pc_r <= 16'h0000;
         st_r <= ST_IDLE;
         cnt_r <= 3'h0;
         lookup_r <= 1'b0;
         flags_r <= `DEC_FLAGS_RST;
         pc_r <= 16'h0000;
         icr_r <= `DEC_ICR_RST;
         halt_r <= 1'b0;
         pass_r <= 1'b0;
         pass_op_r <= 8'h00;
         sp_r <= 16'h0000;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         addr_r <= addr_nxt;
         hrdata_o <= rdata_nxt;
         opcode_r <= opcode_nxt;
         operand_r <= operand_nxt;
         wreg_r <= wreg_nxt;
         stack_flags_r <= stack_flags_nxt;
         stack_pc_r <= stack_pc_nxt;
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         lookup_r <= lookup_nxt;
         flags_r <= flags_nxt;
         pc_r <= pc_nxt;
         icr_r <= icr_nxt;
         halt_r <= halt_nxt;
         pass_r <= pass_nxt;
         pass_op_r <= pass_op_nxt;
         sp_r <= sp_nxt;
      end
   end
   // Zero-wait slave: every transfer completes in one data-phase cycle
   always_comb begin
      hreadyout_o = 1'b1;
      hresp_o = 1'b0;
   end
   always_comb begin
      pc_o = pc_r;
      flags_o = flags_r;
      irq_ctrl_o = icr_r;
      halt_o = halt_r;
      pass_o = pass_r;
      pass_opcode_o = pass_op_r;
   end
   decode_rom u_rom (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .opcode_i(opcode_r),
      .fetch_cyc_o(fcyc),
      .exec_cyc_o(ecyc),
      .mode_o(mode),
      .fx_o(fx),
      .hit_o(hit)
   );
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_di_clears;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == ST_EXEC && cnt_r == 3'h0 && opcode_r == 8'h8F) |=> !icr_r[7];
   endproperty
   a_di_clears: assert property (p_di_clears) else $error("DI left enable set");
   property p_ei_sets;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == ST_EXEC && cnt_r == 3'h0 && opcode_r == 8'h9F) |=> icr_r[7];
   endproperty
   a_ei_sets: assert property (p_ei_sets) else $error("EI left enable clear");
   property p_halt;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == ST_EXEC && cnt_r == 3'h0 && opcode_r == 8'h7F) |=> halt_r;
   endproperty
   a_halt: assert property (p_halt) else $error("Halt not entered");
   property p_pass_keeps;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == ST_IDLE && lookup_r && !hit) |=> pass_r && $stable(pc_r) && $stable(flags_r);
   endproperty
   a_pass_keeps: assert property (p_pass_keeps) else $error("Pass-through changed state");
   property p_ret_sp;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == ST_EXEC && cnt_r == 3'h0 && opcode_r == 8'hBF)
         |=> sp_r == $past(sp_r) + 16'h0003 && icr_r[7];
   endproperty
   a_ret_sp: assert property (p_ret_sp) else $error("Return did not pop");
   property p_ret_flags;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == ST_EXEC && cnt_r == 3'h0 && opcode_r == 8'hBF)
         |=> flags_r == $past(stack_flags_r) && pc_r == $past(stack_pc_r);
   endproperty
   a_ret_flags: assert property (p_ret_flags) else $error("Return lost state");
   property p_fetch_len;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      ($rose(st_r == ST_FETCH) && cnt_r == 3'h1) |-> (st_r == ST_FETCH) [*2] ##1 st_r == ST_EXEC;
   endproperty
   a_fetch_len: assert property (p_fetch_len) else $error("Fetch length wrong");
   property p_adc_time;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == ST_IDLE && lookup_r && opcode_r == 8'h12) |=> (st_r == ST_FETCH) [*2]
         ##1 (st_r == ST_EXEC) [*3] ##1 st_r == ST_IDLE;
   endproperty
   a_adc_time: assert property (p_adc_time) else $error("ADC r,r timing wrong");
   property p_add_fx;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == ST_FETCH && opcode_r[7:4] == 4'h0 && opcode_r[3:0] == 4'h4)
         |-> fx[5:3] == FX_ZERO && fcyc == 3'h3;
   endproperty
   a_add_fx: assert property (p_add_fx) else $error("ADD decimal flag wrong");
   property p_jp_direct;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == ST_EXEC && cnt_r == 3'h0 && opcode_r == 8'h8D) |=> pc_r == $past(operand_r);
   endproperty
   a_jp_direct: assert property (p_jp_direct) else $error("Jump missed");
   property p_loop_fall;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == ST_EXEC && cnt_r == 3'h0 && opcode_r[3:0] == 4'hA && wreg_r == 8'h01)
         |=> $stable(pc_r);
   endproperty
   a_loop_fall: assert property (p_loop_fall) else $error("Loop branch taken at zero");
   property p_cond_never;
      @(posedge clk_sys_i) disable iff (!arst_n_i)
      (st_r == ST_EXEC && cnt_r == 3'h0 && opcode_r == 8'h0D) |=> $stable(pc_r);
   endproperty
   a_cond_never: assert property (p_cond_never) else $error("Never-jump moved");
endmodule

// ---- hdl/instr_decode_regs.svh ----
`ifndef INSTR_DECODE_REGS_SVH
`define INSTR_DECODE_REGS_SVH
// Bus map
`define DEC_OFS_CTRL 8'h00
`define DEC_OFS_OPCODE 8'h04
`define DEC_OFS_STATUS 8'h08
`define DEC_OFS_FLAGS 8'h0C
`define DEC_OFS_INFO 8'h10
// Field positions
`define DEC_CTRL_GO_BIT 0
`define DEC_STAT_BUSY_BIT 0
`define DEC_STAT_HALT_BIT 1
`define DEC_STAT_IEN_BIT 2
`define DEC_STAT_PASS_BIT 3
`define DEC_IRQ_ENABLE_BIT 7
// Reset values
`define DEC_FLAGS_RST 8'h00
`define DEC_ICR_RST 8'h00
`endif

// ---- hdl/instr_decode_pkg.sv ----
package instr_decode_pkg;
   // Per-flag effect notation
   typedef enum logic [2:0] {
      FX_RESULT = 3'h0,
      FX_KEEP = 3'h1,
      FX_UNDEF = 3'h2,
      FX_ZERO = 3'h3,
      FX_ONE = 3'h4
   } flag_fx_t;
   typedef enum logic [3:0] {
      AM_NONE = 4'h0, AM_R_R = 4'h1, AM_R_IR = 4'h2, AM_RG_RG = 4'h3,
      AM_RG_IRG = 4'h4, AM_RG_IM = 4'h5, AM_IRG_IM = 4'h6, AM_ER_ER = 4'h7,
      AM_ER_IM = 4'h8, AM_RG = 4'h9, AM_IRG = 4'hA, AM_RR = 4'hB,
      AM_IRR = 4'hC, AM_DIR = 4'hD, AM_WR = 4'hE
   } addr_mode_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_FETCH = 3'b010,
      ST_EXEC = 3'b100
   } seq_state_t;
endpackage

// ---- hdl/decode_rom.sv ----
// Registered opcode table: cycles, mode, flag notation, subset hit
module decode_rom
   import instr_decode_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // Lookup
   input wire logic [7:0] opcode_i,
   output logic [2:0] fetch_cyc_o,
   output logic [2:0] exec_cyc_o,
   output logic [3:0] mode_o,
   output logic [17:0] fx_o,
   output logic hit_o
);
   logic [2:0] f_nxt;
   logic [2:0] e_nxt;
   addr_mode_t m_nxt;
   flag_fx_t c_fx, z_fx, s_fx, v_fx, d_fx, h_fx;
   logic hit_nxt;
   logic [3:0] lo;
   logic [3:0] hi;
   always_comb begin
      lo = opcode_i[3:0];
      hi = opcode_i[7:4];
      f_nxt = 3'h0;
      e_nxt = 3'h0;
      m_nxt = AM_NONE;
      hit_nxt = 1'b1;
      c_fx = FX_KEEP; z_fx = FX_KEEP; s_fx = FX_KEEP;
      v_fx = FX_KEEP; d_fx = FX_KEEP; h_fx = FX_KEEP;
      if ((hi == 4'h0 || hi == 4'h1) && lo >= 4'h2 && lo <= 4'h9) begin
         c_fx = FX_RESULT; z_fx = FX_RESULT; s_fx = FX_RESULT;
         v_fx = FX_RESULT; d_fx = FX_ZERO; h_fx = FX_RESULT;
         case (lo)
            4'h2: begin f_nxt = 3'h2; e_nxt = 3'h3; m_nxt = AM_R_R; end
            4'h3: begin f_nxt = 3'h2; e_nxt = 3'h4; m_nxt = AM_R_IR; end
            4'h4: begin f_nxt = 3'h3; e_nxt = 3'h3; m_nxt = AM_RG_RG; end
            4'h5: begin f_nxt = 3'h3; e_nxt = 3'h4; m_nxt = AM_RG_IRG; end
            4'h6: begin f_nxt = 3'h3; e_nxt = 3'h3; m_nxt = AM_RG_IM; end
            4'h7: begin f_nxt = 3'h3; e_nxt = 3'h4; m_nxt = AM_IRG_IM; end
            4'h8: begin f_nxt = 3'h4; e_nxt = 3'h3; m_nxt = AM_ER_ER; end
            default: begin f_nxt = 3'h4; e_nxt = 3'h3; m_nxt = AM_ER_IM; end
         endcase
      end else if (lo == 4'hA) begin
         f_nxt = 3'h2; e_nxt = 3'h3; m_nxt = AM_WR;
      end else if (lo == 4'hE) begin
         f_nxt = 3'h1; e_nxt = 3'h2; m_nxt = AM_WR;
         z_fx = FX_RESULT; s_fx = FX_RESULT; v_fx = FX_RESULT;
      end else if (lo == 4'hD) begin
         f_nxt = 3'h3; e_nxt = 3'h2; m_nxt = AM_DIR;
      end else begin
         case (opcode_i)
            8'h40, 8'h41: begin
               f_nxt = 3'h2; e_nxt = opcode_i[0] ? 3'h3 : 3'h2;
               m_nxt = opcode_i[0] ? AM_IRG : AM_RG;
               c_fx = FX_RESULT; z_fx = FX_RESULT; s_fx = FX_RESULT; v_fx = FX_UNDEF;
            end
            8'h30, 8'h31, 8'h20, 8'h21: begin
               f_nxt = 3'h2; e_nxt = opcode_i[0] ? 3'h3 : 3'h2;
               m_nxt = opcode_i[0] ? AM_IRG : AM_RG;
               z_fx = FX_RESULT; s_fx = FX_RESULT; v_fx = FX_RESULT;
            end
            8'h80, 8'h81, 8'hA0, 8'hA1: begin
               f_nxt = 3'h2; e_nxt = opcode_i[0] ? 3'h6 : 3'h5;
               m_nxt = opcode_i[0] ? AM_IRR : AM_RR;
               z_fx = FX_RESULT; s_fx = FX_RESULT; v_fx = FX_RESULT;
            end
            8'h8F, 8'h9F, 8'h7F: begin f_nxt = 3'h1; e_nxt = 3'h2; end
            8'hBF: begin
               f_nxt = 3'h1; e_nxt = 3'h5;
               c_fx = FX_RESULT; z_fx = FX_RESULT; s_fx = FX_RESULT;
               v_fx = FX_RESULT; d_fx = FX_RESULT; h_fx = FX_RESULT;
            end
            8'hC4: begin f_nxt = 3'h2; e_nxt = 3'h3; m_nxt = AM_IRR; end
            default: hit_nxt = 1'b0;
         endcase
      end
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fetch_cyc_o <= 3'h0;
         exec_cyc_o <= 3'h0;
         mode_o <= 4'h0;
         fx_o <= 18'h0_0000;
         hit_o <= 1'b0;
      end else begin
         fetch_cyc_o <= f_nxt;
         exec_cyc_o <= e_nxt;
         mode_o <= m_nxt;
         fx_o <= {c_fx, z_fx, s_fx, v_fx, d_fx, h_fx};
         hit_o <= hit_nxt;
      end
   end
endmodule

// ---- test/prog_mem.sv ----
module prog_mem (
   // Lookup
   input wire logic [5:0] idx_i,
   // Instruction word and its listed timing
   output logic [7:0] op_o,
   output logic [3:0] fetch_o,
   output logic [3:0] exec_o,
   output logic [3:0] mode_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------
   // Opcode, fetch cycles, execute cycles, mode
   // ---------------------------------------------
   localparam int N = 33;
   localparam logic [19:0] ROM [N] = '{
      20'h1_2231, 20'h1_3242, 20'h1_4333, 20'h1_5344,
      20'h1_6335, 20'h1_7346, 20'h1_8437, 20'h1_9438,
      20'h0_2231, 20'h0_3242, 20'h0_4333, 20'h0_5344,
      20'h0_6335, 20'h0_7346, 20'h0_8437, 20'h0_9438,
      20'h4_0229, 20'h4_123A, 20'h3_0229, 20'h3_123A,
      20'h8_025B, 20'h8_126C, 20'h8_F120, 20'h9_F120,
      20'h3_A23E, 20'h2_0229, 20'h2_123A, 20'h5_E12E,
      20'hA_025B, 20'hA_126C, 20'h8_D32D, 20'hC_423C,
      20'h0_D32D
   };
   // Out-of-range index reads as a never-taken jump, harmless to replay
   always_comb begin
      {op_o, fetch_o, exec_o, mode_o} = (idx_i < 6'(N)) ? ROM[idx_i] : ROM[N-1];
   end
endmodule

// ---- test/tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import instr_decode_pkg::*;
   typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} note_t;
   logic clk_sys_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [7:0] haddr_i = 8'h00;
   logic [1:0] htrans_i = 2'h0;
   logic hwrite_i = 1'b0;
   logic [31:0] hwdata_i = 32'h0000_0000;
   logic [31:0] hrdata_o;
   logic hreadyout_o, hresp_o, halt_o, pass_o;
   logic [15:0] pc_o;
   logic [7:0] flags_o, irq_ctrl_o, pass_opcode_o, t_op;
   logic [3:0] t_f, t_e, t_m;
   logic [5:0] idx = 6'h00;
   logic rd_pend = 1'b0;
   int error_cnt = 0;
   int tests_run = 0;
   integer seed = 32'ha45bc652;
   note_t rd_q[$];
   logic [7:0] pass_q[$];

   instr_decode instr_decode_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .hsel_i(1'b1),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pc_o(pc_o), .flags_o(flags_o),
      .irq_ctrl_o(irq_ctrl_o), .halt_o(halt_o), .pass_o(pass_o),
      .pass_opcode_o(pass_opcode_o));
   prog_mem prog_mem_i (.idx_i(idx), .op_o(t_op), .fetch_o(t_f), .exec_o(t_e), .mode_o(t_m));

   initial begin
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   // ---------------------------------------------
   // Compare and report
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic results();
      $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // Bus master
   // ---------------------------------------------
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (hreadyout_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         results();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk_sys_i);
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= wr;
      wait_rdy();
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      wait_rdy();
      rd = hrdata_o;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(1'b1, a, d, v);
   endtask

   // A zero mask marks a read whose value the caller judges itself
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m, output logic [31:0] v);
      note_t n;
      n.nm = nm;
      n.exp = e;
      n.msk = m;
      rd_q.push_back(n);
      bus(1'b0, a, 32'h0000_0000, v);
   endtask

   // Load opcode and operand, start, poll busy; d is cycles until idle seen
   task automatic run(input logic [7:0] op, input logic [31:0] opnd, output int d);
      logic [31:0] v;
      time t0;
      wr(8'h04, {opnd[31:8], op});
      wr(8'h00, 32'h0000_0001);
      t0 = $time;
      do begin
         rd("poll", 8'h08, 32'h0000_0000, 32'h0000_0000, v);
         d = int'(($time - t0) / 40);
      end while (v[0] !== 1'b0 && d < 60);
      if (d >= 60) begin
         error_cnt++;
         results();
      end
   endtask

   // ---------------------------------------------
   // Output watcher
   // ---------------------------------------------
   always @(posedge clk_sys_i) begin
      note_t n;
      if (rd_pend && hreadyout_o === 1'b1) begin
         n = rd_q.pop_front();
         if (n.msk != 32'h0000_0000) begin
            chk(n.nm, hrdata_o & n.msk, n.exp & n.msk);
         end
      end
      rd_pend = htrans_i === 2'h2 && hwrite_i === 1'b0 && hreadyout_o === 1'b1;
      if (pass_o === 1'b1) begin
         if (pass_q.size() == 0) begin
            chk("pass_unexpected", 32'h1, 32'h0);
         end else begin
            chk("pass_opcode", 32'(pass_opcode_o), 32'(pass_q.pop_front()));
         end
      end
   end

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial begin
      int d;
      logic [31:0] v, r;
      logic [15:0] p1, p2;
      logic [7:0] disp, sp;
      repeat (20) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      chk("pc_rst", 32'(pc_o), 32'h0000_0000);
      chk("halt_rst", 32'(halt_o), 32'h0000_0000);
      chk("hresp_rst", 32'(hresp_o), 32'h0000_0000);
      rd("unmapped", 8'h20, 32'h0000_0000, 32'hFFFF_FFFF, v);
      rd("status_rst", 8'h08, 32'h0000_0000, 32'h0000_000F, v);
      // Every listed opcode: timing window and addressing mode
      for (int i = 0; i < 33; i++) begin
         idx = 6'(i);
         #1;
         run(t_op, $random(seed), d);
         // Busy is polled every third cycle, so idle shows at the next poll after the end
         chk("cycles", 32'(d), 32'(3 * ((t_f + t_e + 2) / 3) + 3));
         rd("mode", 8'h10, 32'(t_m), 32'h0000_000F, v);
      end
      run(8'h9F, 32'h0000_0000, d);
      chk("irq_set", 32'(irq_ctrl_o[7]), 32'h1);
      rd("status_en", 8'h08, 32'h0000_0004, 32'h0000_0004, v);
      run(8'h8F, 32'h0000_0000, d);
      chk("irq_clr", 32'(irq_ctrl_o[7]), 32'h0);
      // Jumps: direct loads, never-condition leaves counter alone
      r = $random(seed);
      run(8'h8D, r, d);
      chk("jp_direct", 32'(pc_o), 32'(r[23:8]));
      run(8'h0D, {r[31:24], ~r[23:8], 8'h00}, d);
      chk("jp_never", 32'(pc_o), 32'(r[23:8]));
      // Loop branch: count 1 falls through, 5 and wrap from 0 both branch
      disp = r[7:0];
      run(8'h8D, 32'h0040_0000, d);
      run(8'h3A, {8'h01, 8'h00, disp, 8'h00}, d);
      p1 = pc_o;
      chk("loop_fall", 32'(p1), 32'h0000_4000);
      run(8'h8D, 32'h0040_0000, d);
      run(8'h3A, {8'h05, 8'h00, disp, 8'h00}, d);
      p2 = pc_o;
      chk("loop_taken", 32'(p2), 32'(16'(p1 + {{8{disp[7]}}, disp})));
      run(8'h8D, 32'h0040_0000, d);
      run(8'h3A, {8'h00, 8'h00, disp, 8'h00}, d);
      chk("loop_wrap", 32'(pc_o), 32'(p2));
      // Opcode outside the subset passes on and changes nothing
      p1 = pc_o;
      v = {24'h00_0000, flags_o};
      pass_q.push_back(8'h01);
      run(8'h01, $random(seed), d);
      chk("pass_pc", 32'(pc_o), 32'(p1));
      chk("pass_flags", 32'(flags_o), v);
      chk("pass_irq", 32'(irq_ctrl_o[7]), 32'h0);
      // Return from interrupt restores flags and counter, enables, pops three
      r = $random(seed);
      wr(8'h10, {8'h00, r[23:8], r[7:0]});
      rd("sp_before", 8'h0C, 32'h0000_0000, 32'h0000_0000, v);
      sp = v[23:16];
      run(8'hBF, 32'h0000_0000, d);
      chk("ret_cycles", 32'(d), 32'h0000_0009);
      chk("ret_flags", 32'(flags_o & 8'hFC), 32'(r[7:0] & 8'hFC));
      chk("ret_pc", 32'(pc_o), 32'(r[23:8]));
      chk("ret_irq", 32'(irq_ctrl_o[7]), 32'h1);
      rd("ret_sp", 8'h0C, {8'h00, 8'(sp + 8'h03), 16'h0000}, 32'h00FF_0000, v);
      // Halt is sticky, so it goes last
      run(8'h7F, 32'h0000_0000, d);
      chk("halt_cycles", 32'(d), 32'h0000_0006);
      chk("halt", 32'(halt_o), 32'h1);
      rd("status_halt", 8'h08, 32'h0000_0002, 32'h0000_0002, v);
      results();
   end
endmodule
